// ==== logic/bax_pkg.sv ====
/*
 * bax_pkg: shared constants and types for the byte alu slice.
 * assumes a single core clock; included by the alu top and its carrier.
 */
package bax_pkg;
    localparam int unsigned BAX_DATA_W    = 8;
    localparam int unsigned BAX_ADDR_W    = 7;
    localparam logic [6:0]  BAX_ADDR_MAX  = 7'h7f;
    localparam logic        BAX_DEST_ACC  = 1'b0;
    localparam logic        BAX_DEST_FILE = 1'b1;
    localparam logic [7:0]  BAX_ACC_RST   = 8'h00;
    localparam logic        BAX_FLAG_RST  = 1'b0;
    localparam int unsigned BAX_LO_HI     = 3;
    localparam int unsigned BAX_HI_LO     = 4;
    localparam int unsigned BAX_LATENCY   = 1;

    typedef enum logic [1:0]
    {
        BAX_OP_SUB_FILE,
        BAX_OP_XOR_FILE,
        BAX_OP_SWAP_FILE,
        BAX_OP_XOR_LIT
    } bax_op_t;
endpackage

// ==== logic/bax_res_if.sv ====
/*
 * bax_res_if: carrier between the combinational result unit and the top.
 * assumes both ends sit on the same core clock.
 */
`timescale 1ns/100ps
interface bax_res_if;
    import bax_pkg::*;
    bax_op_t    op;
    logic [7:0] acc;
    logic [7:0] opnd;
    logic [7:0] result;
    logic       borrow_n;
    logic       nib_borrow_n;
    logic       zero;

    modport unit
    (
        input  op,
        input  acc,
        input  opnd,
        output result,
        output borrow_n,
        output nib_borrow_n,
        output zero
    );
    modport top
    (
        output op,
        output acc,
        output opnd,
        input  result,
        input  borrow_n,
        input  nib_borrow_n,
        input  zero
    );
endinterface

// ==== logic/bax_result_unit.sv ====
/*
 * bax_result_unit: combinational result and flag terms for one operation.
 * assumes operands are stable for the whole cycle they are presented.
 */
`timescale 1ns/100ps
module bax_result_unit
    import bax_pkg::*;
(
    bax_res_if.unit r
);
    logic [8:0] diff;
    logic [4:0] nib_diff;

    always_comb
    begin
        diff     = {1'b0, r.opnd} - {1'b0, r.acc};
        nib_diff = {1'b0, r.opnd[BAX_LO_HI:0]} - {1'b0, r.acc[BAX_LO_HI:0]};
        case (r.op)
            BAX_OP_SUB_FILE:  r.result = diff[7:0];
            BAX_OP_XOR_FILE:  r.result = r.acc ^ r.opnd;
            BAX_OP_SWAP_FILE: r.result = {r.opnd[BAX_LO_HI:0], r.opnd[7:BAX_HI_LO]};
            BAX_OP_XOR_LIT:   r.result = r.acc ^ r.opnd;
            default:          r.result = 8'h00;
        endcase
        r.borrow_n     = ~diff[8];
        r.nib_borrow_n = ~nib_diff[4];
        r.zero         = (r.result == 8'h00);
    end
endmodule

// ==== logic/bax_byte_alu.sv ====
/*
 * bax_byte_alu: byte alu slice with accumulator, borrow, nibble borrow and zero.
 * assumes the decoder issues one op per start pulse and the register file
 * supplies the addressed byte and takes file_wr_en / file_wr_addr / file_wr_data.
 */
`timescale 1ns/100ps
module bax_byte_alu
    import bax_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire bax_op_t    op,
    input  wire logic       dest,
    input  wire logic [6:0] file_addr,
    input  wire logic [7:0] file_data,
    input  wire logic [7:0] literal,
    output logic [7:0]      acc_reg,
    output logic            borrow_flag_reg,
    output logic            nibble_borrow_flag_reg,
    output logic            zero_flag_reg,
    output logic            file_wr_en_reg,
    output logic [6:0]      file_wr_addr_reg,
    output logic [7:0]      file_wr_data_reg,
    output logic            done_reg
);
    bax_res_if r ();

    logic to_file;

    assign r.op   = op;
    assign r.acc  = acc_reg;
    // one operand mux: the literal replaces the file byte only for the literal op
    assign r.opnd = (op == BAX_OP_XOR_LIT) ? literal : file_data;

    bax_result_unit u_unit
    (
        .r (r.unit)
    );

    // destination select; literal op always targets acc
    assign to_file = (op != BAX_OP_XOR_LIT) && (dest == BAX_DEST_FILE);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            acc_reg <= BAX_ACC_RST;
        else if (start && !to_file)
            acc_reg <= r.result;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            file_wr_en_reg   <= 1'b0;
            file_wr_addr_reg <= 7'h00;
            file_wr_data_reg <= 8'h00;
        end
        else
        begin
            file_wr_en_reg <= start && to_file;
            if (start && to_file)
            begin
                file_wr_addr_reg <= file_addr;
                file_wr_data_reg <= r.result;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            borrow_flag_reg        <= BAX_FLAG_RST;
            nibble_borrow_flag_reg <= BAX_FLAG_RST;
        end
        else if (start && op == BAX_OP_SUB_FILE)
        begin
            borrow_flag_reg        <= r.borrow_n;
            nibble_borrow_flag_reg <= r.nib_borrow_n;
        end
    end

    // zero follows the result even when it lands in the file, not the accumulator
    // zero flag, untouched by swap
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            zero_flag_reg <= BAX_FLAG_RST;
        else if (start && op != BAX_OP_SWAP_FILE)
            zero_flag_reg <= r.zero;
    end

    // done marks the edge at which every result of the op is visible
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            done_reg <= 1'b0;
        else
            done_reg <= start;
    end

    AST_SUB_VALUE: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SUB_FILE && dest == BAX_DEST_ACC
        |=> acc_reg == 8'($past(file_data) - $past(acc_reg)))
        else $error("subtract result wrong");
    AST_DEST_FILE: assert property (@(posedge mclk) disable iff (!resetn)
        start && op != BAX_OP_XOR_LIT && dest == BAX_DEST_FILE
        |=> file_wr_en_reg && $stable(acc_reg) && file_wr_addr_reg == $past(file_addr))
        else $error("file destination not honoured");
    AST_BORROW: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SUB_FILE
        |=> borrow_flag_reg == ($past(acc_reg) <= $past(file_data))
            && nibble_borrow_flag_reg == ($past(acc_reg[3:0]) <= $past(file_data[3:0])))
        else $error("borrow flags wrong");
    AST_XOR_FILE: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_XOR_FILE
        |=> $stable(borrow_flag_reg) && $stable(nibble_borrow_flag_reg)
            && (file_wr_en_reg ? file_wr_data_reg : acc_reg)
               == ($past(acc_reg) ^ $past(file_data)))
        else $error("xor with file wrong");
    AST_SWAP: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SWAP_FILE
        |=> $stable(zero_flag_reg) && $stable(borrow_flag_reg)
            && (file_wr_en_reg ? file_wr_data_reg : acc_reg)
               == {$past(file_data[3:0]), $past(file_data[7:4])})
        else $error("swap result or flags wrong");
    AST_XOR_LIT: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_XOR_LIT
        |=> !file_wr_en_reg && acc_reg == ($past(acc_reg) ^ $past(literal)))
        else $error("xor literal wrong");
    AST_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
        start && op != BAX_OP_SWAP_FILE
        |=> zero_flag_reg == ((file_wr_en_reg ? file_wr_data_reg : acc_reg) == 8'h00))
        else $error("zero flag wrong");
    AST_DONE: assert property (@(posedge mclk) disable iff (!resetn)
        start |=> done_reg ##1 (done_reg == $past(start)))
        else $error("done pulse wrong");

    // every result check compares against inputs registered one edge back, so a
    // back-to-back op is judged against the accumulator left by the one before
    // acc holds idle
    AST_ACC_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        !start
        |=> $stable(acc_reg))
        else $error("accumulator changed without an op");
    AST_WR_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        !start
        |=> !file_wr_en_reg && $stable(file_wr_addr_reg)
            && $stable(file_wr_data_reg))
        else $error("file write without an op");
    AST_DEST_ACC: assert property (@(posedge mclk) disable iff (!resetn)
        start && dest == BAX_DEST_ACC
        |=> !file_wr_en_reg)
        else $error("file written for accumulator destination");
    AST_FLAGS_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        !start
        |=> $stable(borrow_flag_reg) && $stable(nibble_borrow_flag_reg)
            && $stable(zero_flag_reg))
        else $error("flags changed without an op");
    AST_SUB_WR_DATA: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SUB_FILE && dest == BAX_DEST_FILE
        |=> $stable(acc_reg)
            && file_wr_data_reg == 8'($past(file_data) - $past(acc_reg)))
        else $error("subtract into file wrong");
    AST_SUB_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SUB_FILE
        |=> zero_flag_reg == (8'($past(file_data) - $past(acc_reg)) == 8'h00))
        else $error("zero flag after subtract wrong");
    AST_XOR_FILE_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_XOR_FILE
        |=> zero_flag_reg == (($past(acc_reg) ^ $past(file_data)) == 8'h00))
        else $error("zero flag after xor with file wrong");
    AST_XOR_FILE_WR: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_XOR_FILE && dest == BAX_DEST_FILE
        |=> $stable(acc_reg) && file_wr_addr_reg == $past(file_addr)
            && file_wr_data_reg == ($past(acc_reg) ^ $past(file_data)))
        else $error("xor into file wrong");
    AST_XOR_LIT_FLAGS: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_XOR_LIT
        |=> $stable(borrow_flag_reg) && $stable(nibble_borrow_flag_reg)
            && zero_flag_reg == (($past(acc_reg) ^ $past(literal)) == 8'h00))
        else $error("flags after xor literal wrong");
    AST_SWAP_NIB: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SWAP_FILE
        |=> $stable(nibble_borrow_flag_reg))
        else $error("swap changed nibble borrow");
    AST_SWAP_ACC: assert property (@(posedge mclk) disable iff (!resetn)
        start && op == BAX_OP_SWAP_FILE && dest == BAX_DEST_ACC
        |=> !file_wr_en_reg
            && acc_reg == {$past(file_data[3:0]), $past(file_data[7:4])})
        else $error("swap into accumulator wrong");
    AST_DONE_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        !start
        |=> !done_reg)
        else $error("done without an op");
endmodule

// ==== dv/bax_regfile_model.sv ====
/*
 * bax_regfile_model: behavioural file register array facing the alu slice.
 * assumes writes arrive as one-cycle pulses and reads are combinational.
 */
`timescale 1ns/100ps
module bax_regfile_model
(
    input  wire logic       mclk,
    input  wire logic [6:0] rd_addr,
    output logic [7:0]      rd_data,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    logic [7:0] mem [128];

    // preload pattern must match the bench shadow copy
    initial
        for (int i = 0; i < 128; i++)
            mem[i] = 8'(i * 37 + 3);

    assign rd_data = mem[rd_addr];

    always @(posedge mclk)
        if (wr_en)
            mem[wr_addr] <= wr_data;
endmodule

// ==== dv/bax_byte_alu_tb.sv ====
/*
 * bax_byte_alu_tb: directed bench for the byte alu slice.
 * assumes a one-cycle answer and a file model that writes on the next edge.
 */
`timescale 1ns/100ps
module bax_byte_alu_tb;
    import bax_pkg::*;
    logic       mclk, resetn, start, dest, c_f, nib_f, z_f, wr_en, done;
    bax_op_t    op;
    logic [6:0] file_addr, wr_addr;
    logic [7:0] file_data, literal, acc, wr_data, e_acc;
    logic       e_c, e_nib, e_z;
    logic [7:0] shadow [128];
    int         mismatches, comparisons;

    bax_byte_alu dut_u (.mclk(mclk), .resetn(resetn), .start(start), .op(op), .dest(dest),
        .file_addr(file_addr), .file_data(file_data), .literal(literal), .acc_reg(acc),
        .borrow_flag_reg(c_f), .nibble_borrow_flag_reg(nib_f), .zero_flag_reg(z_f),
        .file_wr_en_reg(wr_en), .file_wr_addr_reg(wr_addr), .file_wr_data_reg(wr_data),
        .done_reg(done));
    bax_regfile_model rf_u (.mclk(mclk), .rd_addr(file_addr), .rd_data(file_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // idle cycle at the end lets a file write land before the next read
    task automatic run_op(input bax_op_t o, input logic d, input logic [6:0] a,
                          input logic [7:0] k);
        logic [7:0] fv;
        logic [7:0] r;
        logic       wr;
        fv = shadow[a];
        case (o)
            BAX_OP_SUB_FILE:
            begin
                r = fv - e_acc;
                e_c = (e_acc <= fv);
                e_nib = (e_acc[3:0] <= fv[3:0]);
            end
            BAX_OP_XOR_FILE: r = e_acc ^ fv;
            BAX_OP_SWAP_FILE: r = {fv[3:0], fv[7:4]};
            default: r = e_acc ^ k;
        endcase
        if (o != BAX_OP_SWAP_FILE)
            e_z = (r == 8'h00);
        wr = d && (o != BAX_OP_XOR_LIT);
        @(posedge mclk);
        start <= 1'b1;
        op <= o;
        dest <= d;
        file_addr <= a;
        literal <= k;
        @(posedge mclk);
        start <= 1'b0;
        #1;
        if (wr)
            shadow[a] = r;
        else
            e_acc = r;
        check({6'h0, done, wr_en, acc}, {6'h0, 1'b1, wr, e_acc});
        check({13'h0, c_f, nib_f, z_f}, {13'h0, e_c, e_nib, e_z});
        if (wr)
            check({1'b0, wr_addr, wr_data}, {1'b0, a, r});
        @(posedge mclk);
    endtask

    task automatic t_sub();
        run_op(BAX_OP_SUB_FILE, 1'b0, 7'h05, 8'ha5);
        run_op(BAX_OP_SUB_FILE, 1'b1, 7'h00, 8'ha5);
        run_op(BAX_OP_SUB_FILE, 1'b0, 7'h7f, 8'ha5);
        run_op(BAX_OP_XOR_LIT, 1'b0, 7'h03, e_acc ^ shadow[3]);
        run_op(BAX_OP_SUB_FILE, 1'b0, 7'h03, 8'ha5);
        $display("test sub done");
    endtask

    task automatic t_lit();
        run_op(BAX_OP_XOR_LIT, 1'b1, 7'h7f, 8'hff);
        run_op(BAX_OP_XOR_LIT, 1'b1, 7'h7f, e_acc);
        run_op(BAX_OP_XOR_LIT, 1'b0, 7'h00, 8'h5a);
        $display("test literal done");
    endtask

    task automatic t_xor();
        run_op(BAX_OP_XOR_FILE, 1'b1, 7'h09, 8'ha5);
        run_op(BAX_OP_XOR_LIT, 1'b0, 7'h00, e_acc ^ shadow[20]);
        run_op(BAX_OP_XOR_FILE, 1'b0, 7'h14, 8'ha5);
        $display("test xor done");
    endtask

    // flags left from the zero result must survive both swaps
    task automatic t_swap();
        run_op(BAX_OP_XOR_LIT, 1'b0, 7'h00, e_acc);
        run_op(BAX_OP_SWAP_FILE, 1'b1, 7'h14, 8'ha5);
        run_op(BAX_OP_SWAP_FILE, 1'b0, 7'h14, 8'ha5);
        $display("test swap done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial
    begin
        resetn = 1'b0;
        start = 1'b0;
        op = BAX_OP_SUB_FILE;
        dest = 1'b0;
        file_addr = 7'h00;
        literal = 8'h00;
        mismatches = 0;
        comparisons = 0;
        e_acc = BAX_ACC_RST;
        e_c = BAX_FLAG_RST;
        e_nib = BAX_FLAG_RST;
        e_z = BAX_FLAG_RST;
        for (int i = 0; i < 128; i++)
            shadow[i] = 8'(i * 37 + 3);
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        t_sub();
        t_xor();
        t_lit();
        t_swap();
        wrap_up();
    end
endmodule
